// ---- verification/prx_host.sv ----
// i2c host model driving an open-drain bus with a 125 ns clock
`timescale 1ns/1ps
`default_nettype none
module prx_host
(
	output var logic scl,
	output var logic sda_pull,
	input  wire logic sda_line
);
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		#31 sda_pull = ~b;
		#31 scl = 1'b1;
		#31 r = sda_line;
		#32 scl = 1'b0;
	endtask
	// long low phase first so a trailing ack is surely released
	task automatic start();
		sda_pull = 1'b0;
		#90 scl = 1'b1;
		#62 sda_pull = 1'b1;
		#62 scl = 1'b0;
	endtask
	task automatic stop();
		#31 sda_pull = 1'b1;
		#31 scl = 1'b1;
		#62 sda_pull = 1'b0;
		#62;
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic get(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule // prx_host
`default_nettype wire

// ---- verification/prx_monitor.sv ----
// pin-level checks for the proximity control block
`timescale 1ns/1ps
`default_nettype none
module prx_monitor
#(
	parameter [31:0] RATE1_CYCLES = 32'd40
)
(
	input wire logic        SYS_CLK,
	input wire logic        RESET,
	input wire logic        SCL_IN,
	input wire logic        SDA_IN,
	input wire logic        SDA_O,
	input wire logic        SDA_OE,
	input wire logic        INT_O,
	input wire logic        INT_OE,
	input wire logic        MEAS_START,
	input wire logic        MEAS_DONE,
	input wire logic [15:0] MEAS_RESULT,
	input wire logic [4:0]  EMITTER_CODE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	// long enough that no register write can still be in flight
	sequence bus_idle;
		SCL_IN [*8];
	endsequence
	sequence lone_pulse;
		MEAS_START ##1 !MEAS_START [*8];
	endsequence
	AST_EMIT_RANGE: assert property (EMITTER_CODE <= 5'd20)
		else $error("drive code above 20");
	AST_EMIT_RESET: assert property ($past(RESET) |-> EMITTER_CODE == 5'h02)
		else $error("drive code not 2 after reset");
	AST_EMIT_HOLD: assert property (bus_idle |=> $stable(EMITTER_CODE))
		else $error("drive code moved without a write");
	AST_INT_HOLD: assert property (bus_idle ##0 INT_OE |=> INT_OE)
		else $error("interrupt dropped without a clear");
	AST_INT_CAUSE: assert property ($rose(INT_OE) |-> $past(MEAS_DONE))
		else $error("interrupt without a measurement");
	AST_PIN_LEVEL: assert property (!INT_O && !SDA_O)
		else $error("open-drain value not low");
	AST_START_PULSE: assert property (MEAS_START |-> lone_pulse)
		else $error("start pulses too close");
	AST_RESET_QUIET: assert property ($past(RESET) |-> !INT_OE && !MEAS_START)
		else $error("activity right after reset");
endmodule // prx_monitor

bind prx_ctrl prx_monitor #(.RATE1_CYCLES(RATE1_CYCLES)) i_prx_monitor (
	.SYS_CLK(SYS_CLK), .RESET(RESET), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
	.SDA_O(SDA_O), .SDA_OE(SDA_OE), .INT_O(INT_O), .INT_OE(INT_OE),
	.MEAS_START(MEAS_START), .MEAS_DONE(MEAS_DONE),
	.MEAS_RESULT(MEAS_RESULT), .EMITTER_CODE(EMITTER_CODE));
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the proximity control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
	$display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb;
	localparam logic [31:0] RATE1 = 32'd40;
	localparam logic [1:0]  TAG   = 2'h2; // arbitrary value
	logic        SYS_CLK     = 1'b0;
	logic        RESET       = 1'b1;
	logic        MEAS_DONE   = 1'b0;
	logic [15:0] MEAS_RESULT = 16'h0000;
	logic        scl, sda_pull, ack;
	logic [7:0]  d;
	logic [31:0] seed = 32'hB19945D9;
	logic [7:0]  codes[4] = '{8'h00, 8'h14, 8'h15, 8'hFF};
	logic [15:0] th[9] = '{16'h9000, 16'h9000, 16'h9000, 16'h4000,
		16'h9000, 16'h9000, 16'h9000, 16'h9000, 16'h4000};
	int          fail_count = 0, checks = 0, gap = 0, last_gap = 0;
	int          m_stat = 0, m_tally = 0, m_ictl = 0;
	int          m_hi = 'hFFFF, m_lo = 0;
	logic [15:0] q[$];
	wire         SDA_O, SDA_OE, INT_O, INT_OE, MEAS_START, sda_line;
	wire  [4:0]  EMITTER_CODE;
	assign sda_line = sda_pull ? 1'b0 : (SDA_OE ? SDA_O : 1'b1);
	always #5 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK)
		if (MEAS_START)
		begin
			last_gap <= gap;
			gap <= 1;
		end
		else
			gap <= gap + 1;
	prx_ctrl #(.CAL_TAG(TAG), .RATE1_CYCLES(RATE1)) i_prx_ctrl (
		.SYS_CLK(SYS_CLK), .RESET(RESET), .SCL_IN(scl), .SDA_IN(sda_line),
		.SDA_O(SDA_O), .SDA_OE(SDA_OE), .INT_O(INT_O), .INT_OE(INT_OE),
		.MEAS_START(MEAS_START), .MEAS_DONE(MEAS_DONE),
		.MEAS_RESULT(MEAS_RESULT), .EMITTER_CODE(EMITTER_CODE));
	prx_host i_prx_host (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		i_prx_host.start();
		i_prx_host.put(8'h26, ack);
		i_prx_host.put(a, ack);
		i_prx_host.put(v, ack);
		`CHK("write ack", 1'b1, ack)
		i_prx_host.stop();
	endtask
	task automatic rd(input logic [7:0] a);
		i_prx_host.start();
		i_prx_host.put(8'h26, ack);
		i_prx_host.put(a, ack);
		i_prx_host.start();
		i_prx_host.put(8'h27, ack);
		`CHK("read ack", 1'b1, ack)
		i_prx_host.get(1'b1, d);
		i_prx_host.stop();
	endtask
	// drives one result and steps the reference model alongside
	task automatic meas(input logic [31:0] v);
		int b;
		@(posedge SYS_CLK) #1;
		MEAS_DONE = 1'b1;
		MEAS_RESULT = v[15:0];
		@(posedge SYS_CLK) #1;
		MEAS_DONE = 1'b0;
		q.push_back(v[15:0]);
		b = (v[15:0] > m_hi) ? 1 : ((v[15:0] < m_lo) ? 2 : 0);
		if (m_ictl[3])
			m_stat |= 4;
		if (b != 0 && !m_ictl[0])
			m_tally++;
		else
			m_tally = 0;
		if (m_tally == (1 << m_ictl[7:5]))
		begin
			m_tally = 0;
			if (m_ictl[1])
				m_stat |= b;
		end
		`CHK("int pin", m_stat != 0, INT_OE)
	endtask
	task automatic stat_chk();
		rd(8'h8E);
		`CHK("status", m_stat[2:0], d[2:0])
		wr(8'h8E, 8'h07);
		m_stat = 0;
		`CHK("int clear", 1'b0, INT_OE)
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge SYS_CLK);
		fail_count++;
		wrap_up();
	end
	initial
	begin
		repeat (8) @(posedge SYS_CLK);
		#1 RESET = 1'b0;
		repeat (4) @(posedge SYS_CLK);
		i_prx_host.start();
		i_prx_host.put(8'h30, ack);
		`CHK("foreign ack", 1'b0, ack)
		i_prx_host.stop();
		rd(8'h83);
		`CHK("led reset", {TAG, 6'h02}, d)
		`CHK("drive reset", 5'h02, EMITTER_CODE)
		rd(8'h89);
		`CHK("ictl reset", 8'h00, d)
		for (int i = 0; i < 5; i++)
		begin
			d = (i < 4) ? codes[i] : rnd();
			wr(8'h83, d);
			`CHK("drive", (d[5:0] > 6'd20) ? 5'd20 : d[4:0], EMITTER_CODE)
			rd(8'h83);
			`CHK("tag", TAG, d[7:6])
		end
		for (int c = 1; c < 3; c++)
		begin
			wr(8'h82, 8'hF8 | c[7:0]);
			rd(8'h82);
			`CHK("rate", c[2:0], d[2:0])
			wr(8'h83, 8'h03 + c[7:0]);
			wr(8'h80, 8'h03);
			wr(8'h83, 8'h09);
			`CHK("period", (2 * RATE1) >> c, last_gap)
			`CHK("held", 5'd3 + c[4:0], EMITTER_CODE)
			wr(8'h80, 8'h00);
			`CHK("applied", 5'd9, EMITTER_CODE)
		end
		for (int i = 1; i < 3; i++)
		begin
			repeat (i) meas(rnd());
			rd(8'h80);
			`CHK("ready set", 1'b1, d[5])
			rd(8'h87);
			`CHK("result hi", q[$][15:8], d)
			rd(8'h80);
			`CHK("ready clr", 1'b0, d[5])
			rd(8'h88);
			`CHK("result lo", q[$][7:0], d)
		end
		meas(rnd());
		rd(8'h88);
		rd(8'h80);
		`CHK("ready clr lo", 1'b0, d[5])
		wr(8'h89, 8'h08);
		m_ictl = 8'h08;
		meas(rnd());
		stat_chk();
		wr(8'h8C, 8'h80);
		wr(8'h8D, 8'h00);
		wr(8'h8A, 8'h00);
		wr(8'h8B, 8'h10);
		m_hi = 'h8000;
		m_lo = 'h0010;
		wr(8'h89, 8'h42);
		m_ictl = 8'h42;
		foreach (th[i])
			meas(th[i]);
		stat_chk();
		wr(8'h89, 8'h02);
		m_ictl = 8'h02;
		meas(32'h0001);
		stat_chk();
		wr(8'h89, 8'h2A);
		m_ictl = 8'h2A;
		repeat (8) meas(rnd());
		stat_chk();
		wrap_up();
	end
endmodule // tb
`default_nettype wire

// ---- verilog/prx_ctrl.v ----
// proximity rate, emitter drive, result and threshold interrupt control
`timescale 1ns/1ps
`default_nettype none
`include "prx_defs.vh"

module prx_ctrl
#(
	parameter [1:0]  CAL_TAG      = 2'h1, // arbitrary value
	parameter [31:0] RATE1_CYCLES =
		`PRX_RATE1_PERIOD_NS / `PRX_CLK_PERIOD_NS
)
(
	input  wire        SYS_CLK,
	input  wire        RESET,
	input  wire        SCL_IN,
	input  wire        SDA_IN,
	output wire        SDA_O,
	output wire        SDA_OE,
	output wire        INT_O,
	output wire        INT_OE,
	output reg         MEAS_START,
	input  wire        MEAS_DONE,
	input  wire [15:0] MEAS_RESULT,
	output reg  [4:0]  EMITTER_CODE
);

	wire [7:0]  bus_addr;
	wire [7:0]  bus_wdata;
	wire        bus_wr;
	wire        bus_rd;
	reg  [7:0]  bus_rdata;

	reg         selftimed_reg;
	reg         prox_en_reg;
	reg         data_rdy_reg;
	reg  [2:0]  rate_reg;
	reg  [5:0]  led_reg;
	reg  [15:0] result_reg;
	reg  [7:0]  int_ctl_reg;
	reg  [15:0] th_low_reg;
	reg  [15:0] th_high_reg;
	reg  [2:0]  status_reg;
	reg  [2:0]  status_next;
	reg         run_reg;
	reg  [31:0] timer_reg;
	reg  [7:0]  tally_reg;
	reg  [7:0]  tally_next;
	reg         ondemand_go;

	wire        run_now;
	wire [31:0] period;
	wire [7:0]  need;
	wire        above;
	wire        below;
	wire        beyond;
	wire        th_fire;
	wire [4:0]  led_clamped;
	wire [5:0]  led_lim;
	wire [7:0]  rd_addr;

	prx_i2c_slave u_i2c
	(
		.clk      (SYS_CLK),
		.rst      (RESET),
		.scl_in   (SCL_IN),
		.sda_in   (SDA_IN),
		.sda_oe   (SDA_OE),
		.reg_addr (bus_addr),
		.wr_data  (bus_wdata),
		.wr_stb   (bus_wr),
		.rd_stb   (bus_rd),
		.rd_data  (bus_rdata)
	);

	assign SDA_O  = 1'b0;
	assign INT_O  = 1'b0;
	assign INT_OE = |status_reg;

	// register read mux, unmapped addresses read zero
	always @*
	begin
		case (bus_addr)
		`PRX_ADDR_CMD:
		begin
			bus_rdata = 8'h00;
			bus_rdata[`PRX_CMD_LOCK]      = 1'b1;
			bus_rdata[`PRX_CMD_DATA_RDY]  = data_rdy_reg;
			bus_rdata[`PRX_CMD_PROX_EN]   = prox_en_reg;
			bus_rdata[`PRX_CMD_SELFTIMED] = selftimed_reg;
		end
		`PRX_ADDR_RATE:     bus_rdata = {5'h00, rate_reg};
		`PRX_ADDR_LED:      bus_rdata = {CAL_TAG, led_reg};
		`PRX_ADDR_RES_HI:   bus_rdata = result_reg[15:8];
		`PRX_ADDR_RES_LO:   bus_rdata = result_reg[7:0];
		`PRX_ADDR_INT_CTL:  bus_rdata = int_ctl_reg;
		`PRX_ADDR_THL_HI:   bus_rdata = th_low_reg[15:8];
		`PRX_ADDR_THL_LO:   bus_rdata = th_low_reg[7:0];
		`PRX_ADDR_THH_HI:   bus_rdata = th_high_reg[15:8];
		`PRX_ADDR_THH_LO:   bus_rdata = th_high_reg[7:0];
		`PRX_ADDR_INT_STAT: bus_rdata = {5'h00, status_reg};
		default:            bus_rdata = 8'h00;
		endcase
	end

	// control and threshold registers
	always @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			selftimed_reg <= 1'b0;
			prox_en_reg   <= 1'b0;
			rate_reg      <= `PRX_RATE_RESET;
			led_reg       <= `PRX_LED_RESET;
			int_ctl_reg   <= `PRX_ICTL_RESET;
			th_low_reg    <= 16'h0000;
			th_high_reg   <= 16'hFFFF;
			ondemand_go   <= 1'b0;
		end
		else
		begin
			ondemand_go <= 1'b0;
			if (bus_wr)
			begin
				case (bus_addr)
				`PRX_ADDR_CMD:
				begin
					selftimed_reg <= bus_wdata[`PRX_CMD_SELFTIMED];
					prox_en_reg   <= bus_wdata[`PRX_CMD_PROX_EN];
					// on-demand only when the sequencer is off
					ondemand_go   <= bus_wdata[`PRX_CMD_ONDEMAND] &
						~selftimed_reg & ~bus_wdata[`PRX_CMD_SELFTIMED];
				end
				`PRX_ADDR_RATE:
					// rate changes are only taken while sequencer is off
					if (!selftimed_reg)
						rate_reg <= bus_wdata[`PRX_RATE_MSB:0];
				`PRX_ADDR_LED:
					led_reg <= bus_wdata[`PRX_LED_FIELD_MSB:0];
				`PRX_ADDR_INT_CTL:
					int_ctl_reg <= bus_wdata;
				`PRX_ADDR_THL_HI: th_low_reg[15:8]  <= bus_wdata;
				`PRX_ADDR_THL_LO: th_low_reg[7:0]   <= bus_wdata;
				`PRX_ADDR_THH_HI: th_high_reg[15:8] <= bus_wdata;
				`PRX_ADDR_THH_LO: th_high_reg[7:0]  <= bus_wdata;
				default:          th_low_reg        <= th_low_reg;
				endcase
			end
		end
	end

	// emitter drive: clamp, and freeze while the sequencer runs
	assign led_lim     = (led_reg > `PRX_LED_MAX_CODE) ?
		`PRX_LED_MAX_CODE : led_reg;
	assign led_clamped = led_lim[4:0];
	assign run_now = selftimed_reg & prox_en_reg;
	assign period  = (RATE1_CYCLES << 1) >> rate_reg;

	always @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			run_reg      <= 1'b0;
			timer_reg    <= 32'h0000_0000;
			MEAS_START   <= 1'b0;
			EMITTER_CODE <= `PRX_EMIT_RESET;
		end
		else
		begin
			run_reg    <= run_now;
			MEAS_START <= ondemand_go;
			// new drive value is picked up on every clock while the sequencer is not running
			if (!run_reg)
				EMITTER_CODE <= led_clamped;
			if (!run_now)
				timer_reg <= 32'h0000_0000;
			else if (!run_reg || timer_reg == 32'h0000_0000)
			begin
				timer_reg  <= period - 32'h0000_0001;
				MEAS_START <= 1'b1;
			end
			else
				timer_reg <= timer_reg - 32'h0000_0001;
		end
	end

	// threshold qualification
	assign need   = 8'h01 << int_ctl_reg[`PRX_ICTL_CNT_MSB:`PRX_ICTL_CNT_LSB];
	assign above  = MEAS_RESULT > th_high_reg;
	assign below  = MEAS_RESULT < th_low_reg;
	assign beyond = ~int_ctl_reg[`PRX_ICTL_SEL] & (above | below);
	assign th_fire = MEAS_DONE & beyond &
		(tally_reg + 8'h01 >= need);

	always @*
	begin
		tally_next = tally_reg;
		if (MEAS_DONE)
		begin
			if (!beyond || th_fire)
				tally_next = 8'h00;
			else
				tally_next = tally_reg + 8'h01;
		end
	end

	// the pointer has already moved past the byte when the fetch strobe shows
	assign rd_addr = bus_addr - 8'h01;

	// sticky status: write-one clears, a same-cycle event wins
	always @*
	begin
		status_next = status_reg;
		if (bus_wr && bus_addr == `PRX_ADDR_INT_STAT)
			status_next = status_reg & ~bus_wdata[2:0];
		if (MEAS_DONE && int_ctl_reg[`PRX_ICTL_RDY_EN])
			status_next[`PRX_STAT_READY] = 1'b1;
		if (th_fire && int_ctl_reg[`PRX_ICTL_THR_EN])
		begin
			if (above)
				status_next[`PRX_STAT_UPPER] = 1'b1;
			else
				status_next[`PRX_STAT_LOWER] = 1'b1;
		end
	end

	always @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			result_reg   <= 16'h0000;
			data_rdy_reg <= 1'b0;
			tally_reg    <= 8'h00;
			status_reg   <= 3'h0;
		end
		else
		begin
			tally_reg  <= tally_next;
			status_reg <= status_next;
			if (MEAS_DONE)
			begin
				result_reg   <= MEAS_RESULT;
				data_rdy_reg <= 1'b1;
			end
			else if (bus_rd && (rd_addr == `PRX_ADDR_RES_HI ||
				rd_addr == `PRX_ADDR_RES_LO))
				data_rdy_reg <= 1'b0;
		end
	end

endmodule // prx_ctrl

`default_nettype wire

// ---- verilog/prx_defs.vh ----
// register map, field layout, reset values and timing of the proximity block
`ifndef PRX_DEFS_VH
`define PRX_DEFS_VH

`define PRX_I2C_ADDR        7'h13
`define PRX_ADDR_CMD        8'h80
`define PRX_ADDR_RATE       8'h82
`define PRX_ADDR_LED        8'h83
`define PRX_ADDR_RES_HI     8'h87
`define PRX_ADDR_RES_LO     8'h88
`define PRX_ADDR_INT_CTL    8'h89
`define PRX_ADDR_THL_HI     8'h8A
`define PRX_ADDR_THL_LO     8'h8B
`define PRX_ADDR_THH_HI     8'h8C
`define PRX_ADDR_THH_LO     8'h8D
`define PRX_ADDR_INT_STAT   8'h8E

`define PRX_CMD_SELFTIMED   0
`define PRX_CMD_PROX_EN     1
`define PRX_CMD_ONDEMAND    3
`define PRX_CMD_DATA_RDY    5
`define PRX_CMD_LOCK        7

`define PRX_RATE_MSB        2
`define PRX_RATE_RESET      3'h0

`define PRX_LED_FIELD_MSB   5
`define PRX_LED_TAG_LSB     6
`define PRX_LED_RESET       6'h02
`define PRX_LED_MAX_CODE    6'h14
`define PRX_EMIT_RESET      5'h02

`define PRX_ICTL_SEL        0
`define PRX_ICTL_THR_EN     1
`define PRX_ICTL_RDY_EN     3
`define PRX_ICTL_CNT_LSB    5
`define PRX_ICTL_CNT_MSB    7
`define PRX_ICTL_RESET      8'h00

`define PRX_STAT_UPPER      0
`define PRX_STAT_LOWER      1
`define PRX_STAT_READY      2

// code 001 paces one measurement every 256 ms, each lower code doubles it
`define PRX_RATE1_PERIOD_NS 256000000
`define PRX_CLK_PERIOD_NS   10

`endif

// ---- verilog/prx_i2c_slave.v ----
// i2c target: byte pointer, register write strobe and read fetch strobe
`timescale 1ns/1ps
`default_nettype none
`include "prx_defs.vh"

module prx_i2c_slave
(
	input  wire       clk,
	input  wire       rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_oe,
	output reg  [7:0] reg_addr,
	output reg  [7:0] wr_data,
	output reg        wr_stb,
	output reg        rd_stb,
	input  wire [7:0] rd_data
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_AACK = 3'h2;
	localparam [2:0] ST_WR   = 3'h3;
	localparam [2:0] ST_WACK = 3'h4;
	localparam [2:0] ST_RD   = 3'h5;
	localparam [2:0] ST_RACK = 3'h6;

	reg  [1:0] scl_sync_reg;
	reg  [1:0] sda_sync_reg;
	reg        scl_prev_reg;
	reg        sda_prev_reg;
	reg  [2:0] state_reg;
	reg  [3:0] cnt_reg;
	reg  [7:0] sr_reg;
	reg  [7:0] tx_reg;
	reg        rw_reg;
	reg        first_reg;
	reg        nack_reg;

	wire scl_s   = scl_sync_reg[1];
	wire sda_s   = sda_sync_reg[1];
	wire scl_r   = scl_s & ~scl_prev_reg;
	wire scl_f   = ~scl_s & scl_prev_reg;
	wire start_c = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	wire stop_c  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
	wire rx_st   = (state_reg == ST_ADDR) || (state_reg == ST_WR);

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			state_reg    <= ST_IDLE;
			cnt_reg      <= 4'h0;
			sr_reg       <= 8'h00;
			tx_reg       <= 8'h00;
			rw_reg       <= 1'b0;
			first_reg    <= 1'b0;
			nack_reg     <= 1'b0;
			sda_oe       <= 1'b0;
			reg_addr     <= 8'h00;
			wr_data      <= 8'h00;
			wr_stb       <= 1'b0;
			rd_stb       <= 1'b0;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
			wr_stb       <= 1'b0;
			rd_stb       <= 1'b0;
			if (start_c)
			begin
				state_reg <= ST_ADDR;
				cnt_reg   <= 4'h0;
				sda_oe    <= 1'b0;
			end
			else if (stop_c)
			begin
				state_reg <= ST_IDLE;
				sda_oe    <= 1'b0;
			end
			else if (scl_r)
			begin
				if (rx_st || state_reg == ST_RD)
					cnt_reg <= cnt_reg + 4'h1;
				if (rx_st)
					sr_reg <= {sr_reg[6:0], sda_s};
				if (state_reg == ST_RACK)
					nack_reg <= sda_s;
			end
			else if (scl_f)
			begin
				case (state_reg)
				ST_ADDR:
					if (cnt_reg == 4'h8)
					begin
						cnt_reg <= 4'h0;
						if (sr_reg[7:1] == `PRX_I2C_ADDR)
						begin
							rw_reg    <= sr_reg[0];
							sda_oe    <= 1'b1;
							state_reg <= ST_AACK;
						end
						else
							state_reg <= ST_IDLE;
					end
				ST_AACK, ST_RACK:
					if (state_reg == ST_RACK && nack_reg)
					begin
						sda_oe    <= 1'b0;
						state_reg <= ST_IDLE;
					end
					else if (rw_reg)
					begin
						// fetch at the pointer, then advance for bursts
						tx_reg    <= rd_data;
						sda_oe    <= ~rd_data[7];
						rd_stb    <= 1'b1;
						reg_addr  <= reg_addr + 8'h01;
						state_reg <= ST_RD;
					end
					else
					begin
						sda_oe    <= 1'b0;
						first_reg <= 1'b1;
						state_reg <= ST_WR;
					end
				ST_WR:
					if (cnt_reg == 4'h8)
					begin
						cnt_reg   <= 4'h0;
						sda_oe    <= 1'b1;
						state_reg <= ST_WACK;
						first_reg <= 1'b0;
						if (first_reg)
							reg_addr <= sr_reg;
						else
						begin
							wr_data <= sr_reg;
							wr_stb  <= 1'b1;
						end
					end
				ST_WACK:
				begin
					sda_oe    <= 1'b0;
					state_reg <= ST_WR;
					if (wr_stb == 1'b0 && first_reg == 1'b0)
						reg_addr <= reg_addr;
				end
				ST_RD:
					if (cnt_reg == 4'h8)
					begin
						cnt_reg   <= 4'h0;
						sda_oe    <= 1'b0;
						state_reg <= ST_RACK;
					end
					else
					begin
						tx_reg <= {tx_reg[6:0], 1'b0};
						sda_oe <= ~tx_reg[6];
					end
				default:
					sda_oe <= 1'b0;
				endcase
			end
			if (wr_stb)
				reg_addr <= reg_addr + 8'h01;
		end
	end

endmodule // prx_i2c_slave

`default_nettype wire
